// ==== aoc_channel.sv ====
/*
 * Output channel control: clamp, slew, fault/program action, hold-until-init, alarms.
 * Assumes requests arrive with a one-cycle update strobe from same-clock logic, and that
 * mode pins and unlatch strobes come from same-clock logic too.
 */
`timescale 1ns/1ps
module aoc_channel
    import aoc_pkg::*;
#(
    parameter int unsigned W         = DATA_W,
    parameter int unsigned TICK_CYC  = SLEW_TICK_CYC,
    parameter int unsigned FULL_SPAN = 65535
) (
    input  wire logic                core_clk_i,
    input  wire logic                nrst_i,
    input  wire logic                update_i,
    input  wire logic signed [W-1:0] request_i,
    input  wire logic                prog_mode_i,
    input  wire logic                comm_fault_i,
    input  wire logic                hold_until_init_enable_i,
    input  wire logic                rate_alarm_latch_enable_i,
    input  wire logic                clamp_alarm_latch_enable_i,
    input  wire logic                comm_loss_action_select_i,
    input  wire logic                program_entry_action_select_i,
    input  wire logic                run_slew_enable_i,
    input  wire logic                program_slew_enable_i,
    input  wire logic                comm_loss_slew_enable_i,
    input  wire logic [RATE_W-1:0]   max_slew_rate_i,
    input  wire logic signed [W-1:0] comm_loss_preset_value_i,
    input  wire logic signed [W-1:0] program_preset_value_i,
    input  wire logic signed [W-1:0] output_floor_i,
    input  wire logic signed [W-1:0] output_ceiling_i,
    input  wire logic                unlatch_i,
    input  wire logic [1:0]          unlatch_sel_i,
    output logic signed [W-1:0]      out_value_o,
    output logic                     out_update_o,
    output logic                     floor_clamp_alarm_o,
    output logic                     ceiling_clamp_alarm_o,
    output logic                     rate_alarm_o,
    output logic                     init_hold_o,
    output logic                     unlatch_done_o
);
    initial begin
        if (W < 8 || W > 24 || TICK_CYC < 1 || FULL_SPAN < 1)
            $error("aoc_channel: unsupported parameter values");
    end

    logic rst_s1_reg, rst_n_reg;
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_s1_reg <= 1'b0;
            rst_n_reg  <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_n_reg  <= rst_s1_reg;
        end
    end

    // Slew tick divider: one-cycle enable per tick period.
    logic [31:0] tick_cnt_reg;
    wire  logic  tick = (tick_cnt_reg == 32'(TICK_CYC - 1));
    always_ff @(posedge core_clk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) tick_cnt_reg <= 32'h0;
        else            tick_cnt_reg <= tick ? 32'h0 : tick_cnt_reg + 32'h1;
    end

    // Mode tracking.
    aoc_mode_t mode_reg, mode_next;
    assign mode_next = comm_fault_i ? AOC_FAULT : prog_mode_i ? AOC_PROG : AOC_RUN;
    wire logic enter_fault = (mode_next == AOC_FAULT) && (mode_reg != AOC_FAULT);
    wire logic enter_prog  = (mode_next == AOC_PROG) && (mode_reg == AOC_RUN);
    wire logic enter_run   = (mode_next == AOC_RUN) && (mode_reg != AOC_RUN);

    // Clamp the run request.
    wire logic below  = request_i < output_floor_i;
    wire logic above  = request_i > output_ceiling_i;
    wire logic signed [W-1:0] clamped = below ? output_floor_i :
                                        above ? output_ceiling_i : request_i;

    // Slew step per tick: rate% of span per second spread over the ticks.
    wire logic [47:0] step_raw = (48'(max_slew_rate_i) * 48'(FULL_SPAN))
                                 / 48'(100 * SLEW_TICKS_SEC);
    wire logic [W-1:0] step = (step_raw == 48'h0) ? W'(1) :
                              (step_raw > 48'((1 << (W-1)) - 1)) ? W'((1 << (W-1)) - 1)
                                                                 : step_raw[W-1:0];

    // Hold-until-init window.
    wire logic signed [W:0] gap = {clamped[W-1], clamped} - {out_value_o[W-1], out_value_o};
    wire logic [W:0] gap_abs   = gap[W] ? (W+1)'(-gap) : gap;
    wire logic       init_near = gap_abs <= (W+1)'(FULL_SPAN / INIT_WIN_DIV);

    logic hold_reg, fixed_reg;
    logic signed [W-1:0] target_reg;
    logic slew_on_reg;

    // Target and slew selection per mode.
    wire logic fault_go = comm_loss_action_select_i;
    wire logic prog_go  = program_entry_action_select_i;
    wire logic signed [W-1:0] run_tgt = clamped;

    logic signed [W-1:0] stepped;
    aoc_slew_step #(.W(W)) u_step (
        .cur_i  (out_value_o),
        .tgt_i  (target_reg),
        .step_i (step),
        .next_o (stepped)
    );
    wire logic signed [W-1:0] applied = slew_on_reg ? stepped : target_reg;
    wire logic moving = (out_value_o != target_reg) && !hold_reg && !fixed_reg;
    wire logic apply  = moving && (!slew_on_reg || tick);

    always_ff @(posedge core_clk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            mode_reg    <= AOC_RUN;
            target_reg  <= '0;
            slew_on_reg <= 1'b0;
            fixed_reg   <= 1'b0;
            hold_reg    <= 1'b1;
            out_value_o <= '0;
            out_update_o <= 1'b0;
        end else begin
            mode_reg     <= mode_next;
            out_update_o <= apply;
            if (apply) out_value_o <= applied;
            if (enter_fault) begin
                target_reg  <= comm_loss_preset_value_i;
                fixed_reg   <= !fault_go;
                slew_on_reg <= comm_loss_slew_enable_i;
            end else if (enter_prog) begin
                target_reg  <= program_preset_value_i;
                fixed_reg   <= !prog_go;
                slew_on_reg <= program_slew_enable_i;
            end else if (enter_run) begin
                fixed_reg   <= 1'b0;
                hold_reg    <= hold_until_init_enable_i;
            end else if (mode_reg == AOC_RUN && update_i) begin
                if (hold_reg && !init_near) begin
                    hold_reg <= 1'b1;
                end else begin
                    hold_reg    <= 1'b0;
                    target_reg  <= run_tgt;
                    slew_on_reg <= run_slew_enable_i;
                end
            end
            if (mode_reg == AOC_RUN && !hold_until_init_enable_i && hold_reg)
                hold_reg <= 1'b0;
        end
    end
    assign init_hold_o = hold_reg;

    // Alarms: clamp conditions come from the update strobe; the rate alarm flags a limited move.
    logic lo_cond_reg, hi_cond_reg, rate_cond_reg;
    wire logic rate_cond = slew_on_reg && (out_value_o != target_reg);
    // Unlatch service waits through every cycle in which the cyclic update is busy (update strobe or output apply).
    logic pend_reg;
    logic [1:0] pend_sel_reg;
    wire logic svc_go  = pend_reg && !update_i && !apply;
    wire logic clr_lo  = svc_go && (pend_sel_reg == UNL_FLOOR   || pend_sel_reg == UNL_ALL);
    wire logic clr_hi  = svc_go && (pend_sel_reg == UNL_CEILING || pend_sel_reg == UNL_ALL);
    wire logic clr_rt  = svc_go && (pend_sel_reg == UNL_RATE    || pend_sel_reg == UNL_ALL);
    wire logic set_lo  = update_i && mode_reg == AOC_RUN && below;
    wire logic set_hi  = update_i && mode_reg == AOC_RUN && above;

    always_ff @(posedge core_clk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            lo_cond_reg <= 1'b0;
            hi_cond_reg <= 1'b0;
            rate_cond_reg <= 1'b0;
            floor_clamp_alarm_o   <= 1'b0;
            ceiling_clamp_alarm_o <= 1'b0;
            rate_alarm_o   <= 1'b0;
            pend_reg       <= 1'b0;
            pend_sel_reg   <= 2'h0;
            unlatch_done_o <= 1'b0;
        end else begin
            if (update_i && mode_reg == AOC_RUN) begin
                lo_cond_reg <= below;
                hi_cond_reg <= above;
            end
            rate_cond_reg <= rate_cond;
            if (unlatch_i && !pend_reg) begin
                pend_reg     <= 1'b1;
                pend_sel_reg <= unlatch_sel_i;
            end else if (svc_go) begin
                pend_reg <= 1'b0;
            end
            unlatch_done_o <= svc_go;
            if (clamp_alarm_latch_enable_i) begin
                floor_clamp_alarm_o   <= set_lo | (floor_clamp_alarm_o & ~clr_lo);
                ceiling_clamp_alarm_o <= set_hi | (ceiling_clamp_alarm_o & ~clr_hi);
            end else begin
                floor_clamp_alarm_o   <= update_i ? below : lo_cond_reg;
                ceiling_clamp_alarm_o <= update_i ? above : hi_cond_reg;
            end
            if (rate_alarm_latch_enable_i)
                rate_alarm_o <= rate_cond | (rate_alarm_o & ~clr_rt);
            else
                rate_alarm_o <= rate_cond;
        end
    end

    floor_clamp_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_reg)
        (update_i && mode_reg == AOC_RUN && below) |=> floor_clamp_alarm_o)
        else $error("floor alarm not raised");
    ceil_clamp_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_reg)
        (update_i && mode_reg == AOC_RUN && above) |=> ceiling_clamp_alarm_o)
        else $error("ceiling alarm not raised");
    rate_latch_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_reg)
        (rate_alarm_latch_enable_i && rate_alarm_o && !clr_rt) |=> rate_alarm_o)
        else $error("rate alarm dropped without unlatch");
    clamp_latch_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_reg)
        (clamp_alarm_latch_enable_i && floor_clamp_alarm_o && !clr_lo) |=> floor_clamp_alarm_o)
        else $error("floor alarm dropped without unlatch");
    svc_prio_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_reg)
        svc_go |-> !update_i && !apply)
        else $error("service ran during cyclic update");
    hold_out_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_reg)
        (hold_reg && mode_reg == AOC_RUN) |=> $stable(out_value_o))
        else $error("output moved while held for init");
    fault_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_reg)
        (enter_fault && !comm_loss_action_select_i) |=> fixed_reg ##1 $stable(out_value_o))
        else $error("output moved on fault hold");
    slew_bound_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_reg)
        (apply && slew_on_reg) |=> (out_value_o - $past(out_value_o) <= $signed({1'b0, step})
            && $past(out_value_o) - out_value_o <= $signed({1'b0, step})))
        else $error("slew step exceeded");
    one_svc_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_reg)
        unlatch_done_o |=> !unlatch_done_o)
        else $error("service performed twice");
endmodule : aoc_channel

// ==== aoc_ctrl_model.sv ====
/*
 * Behavioural model of the controller that feeds the output channel: cyclic
 * requests with a one-cycle update strobe, and occasional unlatch services.
 * Assumes the bench calls its tasks and that it shares the channel's clock.
 */
`timescale 1ns/1ps
module aoc_ctrl_model
    import aoc_pkg::*;
(
    input  wire logic               core_clk_i,
    input  wire logic               unlatch_done_i,
    output logic                    update_o,
    output logic signed [DATA_W-1:0] request_o,
    output logic                    unlatch_o,
    output logic [1:0]              unlatch_sel_o
);
    initial begin
        update_o      = 1'b0;
        request_o     = 16'h0000;
        unlatch_o     = 1'b0;
        unlatch_sel_o = 2'h0;
    end

    // A released request line shows the inverse of the last value.
    task automatic send(input logic signed [DATA_W-1:0] v);
        @(negedge core_clk_i);
        update_o  = 1'b1;
        request_o = v;
        @(negedge core_clk_i);
        update_o  = 1'b0;
        request_o = ~v;
    endtask : send

    // One strobe per service, then a bounded wait for the channel to answer.
    task automatic unlatch(input logic [1:0] sel, output bit ok);
        @(negedge core_clk_i);
        unlatch_o     = 1'b1;
        unlatch_sel_o = sel;
        @(negedge core_clk_i);
        unlatch_o     = 1'b0;
        unlatch_sel_o = ~sel;
        ok = 1'b0;
        for (int i = 0; i < 50 && !ok; i++) begin
            if (unlatch_done_i === 1'b1) ok = 1'b1;
            else @(negedge core_clk_i);
        end
    endtask : unlatch
endmodule : aoc_ctrl_model

// ==== aoc_pkg.sv ====
/*
 * Package for the analog output channel control block: timing counts, widths and modes.
 * Assumes a 125 MHz core clock and signed fixed-point output codes.
 */
package aoc_pkg;
    localparam int unsigned CLK_HZ         = 125_000_000;
    // Slew is applied once per slew tick of this period.
    localparam int unsigned SLEW_TICK_US   = 1000;
    localparam int unsigned SLEW_TICK_CYC  = (CLK_HZ / 1_000_000) * SLEW_TICK_US;
    localparam int unsigned SLEW_TICKS_SEC = 1_000_000 / SLEW_TICK_US;
    // Closeness window for hold-until-init, 0.1% of full scale = 1/1000.
    localparam int unsigned INIT_WIN_DIV   = 1000;
    localparam int unsigned DATA_W         = 16;
    localparam int unsigned RATE_W         = 16;
    localparam logic [1:0]  UNL_CEILING    = 2'h0;
    localparam logic [1:0]  UNL_FLOOR      = 2'h1;
    localparam logic [1:0]  UNL_RATE       = 2'h2;
    localparam logic [1:0]  UNL_ALL        = 2'h3;
    typedef enum logic [1:0] {AOC_RUN, AOC_PROG, AOC_FAULT} aoc_mode_t;
endpackage : aoc_pkg

// ==== aoc_slew_step.sv ====
/*
 * One slew step: moves a present value toward a target by at most a given step.
 * Purely combinational; the caller registers the result.
 */
`timescale 1ns/1ps
module aoc_slew_step
    import aoc_pkg::*;
#(
    parameter int unsigned W = DATA_W
) (
    input  wire logic signed [W-1:0] cur_i,
    input  wire logic signed [W-1:0] tgt_i,
    input  wire logic        [W-1:0] step_i,
    output logic signed      [W-1:0] next_o
);
    wire logic signed [W:0] diff  = W'(0) + ({tgt_i[W-1], tgt_i} - {cur_i[W-1], cur_i});
    wire logic signed [W:0] stp   = {1'b0, step_i};
    wire logic signed [W:0] up    = {cur_i[W-1], cur_i} + stp;
    wire logic signed [W:0] dn    = {cur_i[W-1], cur_i} - stp;
    assign next_o = (diff > stp) ? up[W-1:0] : (diff < -stp) ? dn[W-1:0] : tgt_i;
endmodule : aoc_slew_step

// ==== tb.sv ====
/*
 * Self-checking bench for the output channel: clamp table, then slew, alarm
 * latching, fault and program actions and hold-until-init by hand.
 * Assumes a shortened slew tick of 10 cycles and a full scale of 65535 codes.
 */
`timescale 1ns/1ps
module tb;
    import aoc_pkg::*;
    typedef logic signed [15:0] aoc_val_t;
    typedef struct {aoc_val_t rq; aoc_val_t ov; logic fl; logic ce;} aoc_row_t;
    logic     core_clk_i, nrst_i, prog_mode_i, comm_fault_i, hold_en, rate_lat, clamp_lat;
    logic     fault_sel, prog_sel, run_slew, prog_slew, fault_slew, update_i, unlatch_i;
    logic     out_update_o, floor_alarm, ceil_alarm, rate_alarm_o, init_hold_o, unlatch_done_o;
    logic [1:0] unlatch_sel_i;
    logic [15:0] max_slew_rate_i;
    aoc_val_t request_i, fault_val, prog_val, out_value_o, floor_val, ceil_val;
    int       mismatches, n_checks;
    bit       ok;
    aoc_row_t rows[6] = '{'{16'sh01F4, 16'sh01F4, 0, 0}, '{-16'sh05DC, -16'sh03E8, 1, 0},
        '{16'sh03E8, 16'sh03E8, 0, 0}, '{16'sh03E9, 16'sh03E8, 0, 1},
        '{-16'sh03E8, -16'sh03E8, 0, 0}, '{16'sh0000, 16'sh0000, 0, 0}};

    aoc_channel #(.W(16), .TICK_CYC(10), .FULL_SPAN(65535)) dut_u (.core_clk_i(core_clk_i),
        .nrst_i(nrst_i), .update_i(update_i), .request_i(request_i), .prog_mode_i(prog_mode_i),
        .comm_fault_i(comm_fault_i), .hold_until_init_enable_i(hold_en),
        .rate_alarm_latch_enable_i(rate_lat), .clamp_alarm_latch_enable_i(clamp_lat),
        .comm_loss_action_select_i(fault_sel), .program_entry_action_select_i(prog_sel),
        .run_slew_enable_i(run_slew), .program_slew_enable_i(prog_slew),
        .comm_loss_slew_enable_i(fault_slew), .max_slew_rate_i(max_slew_rate_i),
        .comm_loss_preset_value_i(fault_val), .program_preset_value_i(prog_val),
        .output_floor_i(floor_val), .output_ceiling_i(ceil_val), .unlatch_i(unlatch_i),
        .unlatch_sel_i(unlatch_sel_i), .out_value_o(out_value_o), .out_update_o(out_update_o),
        .floor_clamp_alarm_o(floor_alarm), .ceiling_clamp_alarm_o(ceil_alarm),
        .rate_alarm_o(rate_alarm_o), .init_hold_o(init_hold_o),
        .unlatch_done_o(unlatch_done_o));
    aoc_ctrl_model ctrl_u (.core_clk_i(core_clk_i), .unlatch_done_i(unlatch_done_o),
        .update_o(update_i), .request_o(request_i), .unlatch_o(unlatch_i),
        .unlatch_sel_o(unlatch_sel_i));

    initial begin
        core_clk_i = 1'b0;
        forever #4 core_clk_i = ~core_clk_i;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wait_out(input aoc_val_t exp, input int lim);
        for (int i = 0; i < lim && out_value_o !== exp; i++) @(negedge core_clk_i);
        chk(out_value_o, exp);
    endtask : wait_out

    task automatic wait_upd();
        for (int i = 0; i < 40 && out_update_o !== 1'b1; i++) @(negedge core_clk_i);
    endtask : wait_upd

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : print_verdict

    initial begin
        {nrst_i, prog_mode_i, comm_fault_i, hold_en, rate_lat, clamp_lat} = '0;
        {fault_sel, prog_sel, run_slew, prog_slew, fault_slew} = '0;
        max_slew_rate_i = 16'h0064;
        fault_val = 16'sh012C;
        prog_val  = -16'sh00C8;
        floor_val = -16'sh03E8;
        ceil_val  = 16'sh03E8;
        repeat (2) @(negedge core_clk_i);
        chk(out_value_o, 16'h0000);
        chk(init_hold_o, 1'b1);
        nrst_i = 1'b1;
        repeat (3) @(negedge core_clk_i);
        foreach (rows[i]) begin
            ctrl_u.send(rows[i].rq);
            wait_out(rows[i].ov, 10);
            repeat (3) @(negedge core_clk_i);
            chk(floor_alarm, rows[i].fl);
            chk(ceil_alarm, rows[i].ce);
        end
        run_slew = 1'b1;
        ctrl_u.send(16'sh01F4);
        wait_upd();
        chk(out_value_o, 16'h0041);
        chk(rate_alarm_o, 1'b1);
        wait_out(16'sh01F4, 200);
        repeat (3) @(negedge core_clk_i);
        chk(rate_alarm_o, 1'b0);
        rate_lat = 1'b1;
        ctrl_u.send(16'sh0000);
        wait_out(16'sh0000, 200);
        repeat (3) @(negedge core_clk_i);
        chk(rate_alarm_o, 1'b1);
        ctrl_u.unlatch(UNL_RATE, ok);
        chk(ok, 1'b1);
        @(negedge core_clk_i);
        chk(rate_alarm_o, 1'b0);
        {run_slew, fault_sel, fault_slew, comm_fault_i} = 4'hF;
        wait_upd();
        chk(out_value_o, 16'h0041);
        wait_out(16'sh012C, 200);
        {fault_sel, fault_slew, run_slew, comm_fault_i} = 4'h0;
        prog_mode_i = 1'b1;
        ctrl_u.send(16'sh02BC);
        repeat (20) @(negedge core_clk_i);
        chk(out_value_o, 16'sh012C);
        prog_mode_i = 1'b0;
        repeat (3) @(negedge core_clk_i);
        {prog_sel, prog_slew, prog_mode_i} = 3'h7;
        wait_upd();
        chk(out_value_o, 16'sh00EB);
        wait_out(-16'sh00C8, 200);
        hold_en = 1'b1;
        prog_mode_i = 1'b0;
        repeat (3) @(negedge core_clk_i);
        chk(init_hold_o, 1'b1);
        ctrl_u.send(16'sh01F4);
        repeat (10) @(negedge core_clk_i);
        chk(out_value_o, -16'sh00C8);
        ctrl_u.send(-16'sh0096);
        wait_out(-16'sh0096, 10);
        chk(init_hold_o, 1'b0);
        {hold_en, clamp_lat} = 2'h1;
        ctrl_u.send(16'sh07D0);
        wait_out(16'sh03E8, 10);
        ctrl_u.send(16'sh0000);
        wait_out(16'sh0000, 10);
        repeat (3) @(negedge core_clk_i);
        chk(ceil_alarm, 1'b1);
        ctrl_u.unlatch(UNL_FLOOR, ok);
        @(negedge core_clk_i);
        chk(ceil_alarm, 1'b1);
        fork
            ctrl_u.unlatch(UNL_CEILING, ok);
            begin
                ctrl_u.send(-16'sh012C);
                wait_out(-16'sh012C, 2);
            end
        join
        @(negedge core_clk_i);
        chk(ceil_alarm, 1'b0);
        ctrl_u.send(16'sh07D0);
        wait_out(16'sh03E8, 10);
        repeat (3) @(negedge core_clk_i);
        chk(ceil_alarm, 1'b1);
        print_verdict();
    end
endmodule : tb
